// ### verilog/stc_pkg.sv
// stc_pkg: shared constants and carriers for the 16-bit timer core
// assumes: single 125 MHz clock, byte-wide register port
package stc_pkg;
  // register byte offsets (index = byte address on the plain port)
  localparam logic [4:0] ADR_CNT_LO   = 5'h00;
  localparam logic [4:0] ADR_CNT_HI   = 5'h01;
  localparam logic [4:0] ADR_CMPA_LO  = 5'h02;
  localparam logic [4:0] ADR_CMPA_HI  = 5'h03;
  localparam logic [4:0] ADR_CMPB_LO  = 5'h04;
  localparam logic [4:0] ADR_CMPB_HI  = 5'h05;
  localparam logic [4:0] ADR_CMPC_LO  = 5'h06;
  localparam logic [4:0] ADR_CMPC_HI  = 5'h07;
  localparam logic [4:0] ADR_CAP_LO   = 5'h08;
  localparam logic [4:0] ADR_CAP_HI   = 5'h09;
  localparam logic [4:0] ADR_CTRL_A   = 5'h0a;
  localparam logic [4:0] ADR_CTRL_B   = 5'h0b;
  localparam logic [4:0] ADR_CTRL_C   = 5'h0c;
  localparam logic [4:0] ADR_FLAG     = 5'h0d;
  localparam logic [4:0] ADR_MASK     = 5'h0e;
  localparam logic [4:0] ADR_POWER    = 5'h0f;
  // flag / mask bit positions
  localparam int FB_OVF  = 0;
  localparam int FB_CMPA = 1;
  localparam int FB_CMPB = 2;
  localparam int FB_CMPC = 3;
  localparam int FB_CAP  = 5;
  localparam logic [7:0] FLAG_USED = 8'h2f;
  // control B fields
  localparam int CB_SEL_LO  = 0; // 3-bit clock select
  localparam int CB_MODE_LO = 3; // 3-bit top source select
  localparam int CB_EDGE    = 6; // capture edge, 1 = rising
  localparam int CA_FILT    = 0; // control A: capture filter enable
  localparam int CA_ACMP    = 1; // control A: comparator as capture source
  localparam int CA_PWM     = 2; // control A: pwm flag for channel a
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_SYS  = 3'h1;
  localparam logic [2:0] CS_PRE  = 3'h2;
  localparam logic [2:0] CS_FALL = 3'h6;
  localparam logic [2:0] CS_RISE = 3'h7;
  // top source codes
  localparam logic [2:0] TOP_MAX  = 3'h0;
  localparam logic [2:0] TOP_8    = 3'h1;
  localparam logic [2:0] TOP_9    = 3'h2;
  localparam logic [2:0] TOP_10   = 3'h3;
  localparam logic [2:0] TOP_CMPA = 3'h4;
  localparam logic [2:0] TOP_CAP  = 3'h5;
  // counter landmarks
  localparam logic [15:0] VAL_BOTTOM = 16'h0000;
  localparam logic [15:0] VAL_MAX    = 16'hffff;
  localparam logic [15:0] VAL_T8     = 16'h00ff;
  localparam logic [15:0] VAL_T9     = 16'h01ff;
  localparam logic [15:0] VAL_T10    = 16'h03ff;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [7:0]  RST_POWER  = 8'h01; // timer gated after reset
  localparam int          FILT_LEN   = 4;     // filter agreement samples
  // register port carrier
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } stc_bus_t;
  // counter status carrier
  typedef struct packed {
    logic bottom;
    logic at_max;
    logic at_top;
  } stc_stat_t;
endpackage : stc_pkg

// ### verilog/stc_edge.sv
// stc_edge: optional majority-free filter plus edge detector for one pin
// assumes: pin already synchronous to sys_clk
`timescale 1ns/100ps
module stc_edge (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // control
  input  wire logic filt_en,
  input  wire logic rise_sel,
  // pin and event
  input  wire logic pin,
  output logic      hit
);
  import stc_pkg::*;
  logic [FILT_LEN-1:0] hist;
  logic                level;
  logic                level_d;
  wire                 all_hi = &hist;
  wire                 all_lo = ~|hist;
  wire                 next_level = filt_en ? (all_hi ? 1'b1 :
                                     (all_lo ? 1'b0 : level)) : pin;

  // filter trades FILT_LEN cycles of latency for spike rejection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hist    <= '0;
      level   <= 1'b0;
      level_d <= 1'b0;
    end else begin
      hist    <= {hist[FILT_LEN-2:0], pin};
      level   <= next_level;
      level_d <= level;
    end
  end

  assign hit = rise_sel ? (level & ~level_d) : (~level & level_d);
endmodule : stc_edge

// ### verilog/stc_byte16.sv
// stc_byte16: one 16-bit register with low-byte-triggered load
// assumes: staged high byte supplied by the owner of the shared stage
`timescale 1ns/100ps
module stc_byte16 (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // cpu load path
  input  wire logic        lo_wr,
  input  wire logic [7:0]  lo_data,
  input  wire logic [7:0]  stage,
  // hardware load path, cpu wins
  input  wire logic        hw_ld,
  input  wire logic [15:0] hw_data,
  // contents
  output logic [15:0]      q
);
  import stc_pkg::*;
  // cpu low-byte write joins the staged high byte in one edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      q <= RST_WORD;
    else if (lo_wr)
      q <= {stage, lo_data};
    else if (hw_ld)
      q <= hw_data;
  end
endmodule : stc_byte16

// ### verilog/stc_timer.sv
// stc_timer: 16-bit timer/counter core with byte-wide host access
// assumes: plain register port, read data one cycle after the strobe
`timescale 1ns/100ps
module stc_timer (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_b,
  // register port
  input  wire stc_pkg::stc_bus_t  bus,
  output logic [7:0]              rdata,
  // pins and sources
  input  wire logic               presc_tick,
  input  wire logic               ext_count_pin,
  input  wire logic               capture_input_pin,
  input  wire logic               comparator_out,
  // events and status
  output logic [2:0]              compare_match,
  output logic                    pwm_a_allowed,
  output stc_pkg::stc_stat_t      stat,
  output logic                    irq
);
  import stc_pkg::*;

  // reset release
  logic [1:0]  rst_sync;
  logic        rst_n;
  // byte registers and the shared stage
  logic [7:0]  stage;
  logic [7:0]  ctrl_a;
  logic [7:0]  ctrl_b;
  logic [7:0]  ctrl_c;
  logic [7:0]  flag_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  power_reg;
  // word registers; compare values keep a buffer and an active copy
  logic [15:0] count_value;
  logic [15:0] cmp_active [3];
  logic [15:0] cmp_buf [3];
  logic [15:0] capture_value;
  // helpers
  logic        ext_d;
  logic        count_up;
  logic [7:0]  next_rdata;

  // reset release through two flops; assertion stays asynchronous, but
  // every register below leaves reset on the same clean edge, two edges
  // after the pin rises, so nothing sees a half-released reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // address decode
  // reads have no side effect other than on the stage
  wire wr = bus.wr;
  wire rd = bus.rd;
  wire [4:0] a = bus.addr;
  wire wr_cnt_lo = wr && a == ADR_CNT_LO;
  wire rd_cnt_lo = rd && a == ADR_CNT_LO;
  wire rd_cap_lo = rd && a == ADR_CAP_LO;
  wire wr_cap_lo = wr && a == ADR_CAP_LO;
  // byte registers: one select each, so a bad address simply hits nothing
  wire wr_ctrl_a = wr && a == ADR_CTRL_A;
  wire wr_ctrl_b = wr && a == ADR_CTRL_B;
  wire wr_ctrl_c = wr && a == ADR_CTRL_C;
  wire wr_flag   = wr && a == ADR_FLAG;
  wire wr_mask   = wr && a == ADR_MASK;
  wire wr_power  = wr && a == ADR_POWER;
  wire [2:0] wr_cmp_lo = {wr && a == ADR_CMPC_LO, wr && a == ADR_CMPB_LO,
                          wr && a == ADR_CMPA_LO};
  // any high location write lands in the shared stage
  wire wr_hi = wr && (a == ADR_CNT_HI || a == ADR_CMPA_HI ||
               a == ADR_CMPB_HI || a == ADR_CMPC_HI ||
               a == ADR_CAP_HI);

  // clock selection
  // the power gate wins over every source, so a gated timer never counts
  wire        gated   = power_reg[0];
  wire [2:0]  sel     = ctrl_b[CB_SEL_LO +: 3];
  wire        ext_r   = ext_count_pin & ~ext_d;
  wire        ext_f   = ~ext_count_pin & ext_d;
  // one candidate per source; codes not listed select nothing and the
  // counter then holds, the same as the stop code
  wire        tick_sys  = sel == CS_SYS;
  wire        tick_pre  = sel == CS_PRE && presc_tick;
  wire        tick_fall = sel == CS_FALL && ext_f;
  wire        tick_rise = sel == CS_RISE && ext_r;
  // the pin must hold each level for a clock or its edge is lost
  wire        timer_tick = !gated &&
                (tick_sys || tick_pre || tick_fall || tick_rise);

  // top value selection; the counter only counts up, so modes that run
  // down from the top are not built here
  wire [2:0]  mode = ctrl_b[CB_MODE_LO +: 3];
  wire [15:0] top_value =
      (mode == TOP_8)    ? VAL_T8 :
      (mode == TOP_9)    ? VAL_T9 :
      (mode == TOP_10)   ? VAL_T10 :
      (mode == TOP_CMPA) ? cmp_active[0] :
      (mode == TOP_CAP)  ? capture_value : VAL_MAX;
  // status decodes follow the counter combinationally
  assign stat.bottom = count_value == VAL_BOTTOM;
  assign stat.at_max = count_value == VAL_MAX;
  assign stat.at_top = count_value == top_value;
  // channel a cannot drive pwm while it is the top
  assign pwm_a_allowed = !(ctrl_a[CA_PWM] && mode == TOP_CMPA);

  // single-slope up count wrapping at top
  // a start above the top runs on to 0xffff before it wraps
  wire        wrap = stat.at_top || stat.at_max;
  wire [15:0] next_count = wrap ? VAL_BOTTOM : count_value + 16'h0001;

  // capture trigger path
  logic cap_hit;
  wire  cap_src = ctrl_a[CA_ACMP] ? comparator_out : capture_input_pin;
  stc_edge u_cap_edge (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .filt_en  (ctrl_a[CA_FILT]),
    .rise_sel (ctrl_b[CB_EDGE]),
    .pin      (cap_src),
    .hit      (cap_hit)
  );
  // capture only from edges when it is not acting as top; switching the
  // source can itself look like an edge, so software clears the capture
  // flag after changing it
  wire cap_ld = cap_hit && mode != TOP_CAP;
  stc_byte16 u_cap (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .lo_wr   (wr_cap_lo),
    .lo_data (bus.wdata),
    .stage   (stage),
    .hw_ld   (cap_ld),
    .hw_data (count_value),
    .q       (capture_value)
  );

  // compare channels: buffered value moves to active at bottom or when
  // the pwm flag in control A is clear, whatever the top source
  // in pwm use the new value waits for the wrap so that one period never
  // sees two different compare levels
  wire buf_update = !ctrl_a[CA_PWM] || (timer_tick && wrap);
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cmp
      // cpu side buffer of each compare channel
      stc_byte16 u_cmp (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .lo_wr   (wr_cmp_lo[g]),
        .lo_data (bus.wdata),
        .stage   (stage),
        .hw_ld   (1'b0),
        .hw_data (RST_WORD),
        .q       (cmp_buf[g])
      );
      // active copy is what the counter is compared with
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
          cmp_active[g] <= RST_WORD;
        else if (buf_update)
          cmp_active[g] <= cmp_buf[g];
      end
      // a counter write blocks the match on that edge
      assign compare_match[g] = timer_tick && !wr_cnt_lo &&
                                count_value == cmp_active[g];
    end
  endgenerate

  // counter and external-pin edge history; a cpu write wins over the
  // count on the same edge, and a running counter may skip a match when
  // software moves it past a compare value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= RST_WORD;
      ext_d       <= 1'b0;
    end else begin
      ext_d <= ext_count_pin;
      if (wr_cnt_lo)
        count_value <= {stage, bus.wdata};
      else if (timer_tick)
        count_value <= next_count;
    end
  end
  assign count_up = timer_tick && !wr_cnt_lo && wrap;

  // shared high-byte stage; compare reads leave it alone. the stage is
  // one byte for all word registers, so two word accesses that interleave
  // corrupt each other: software keeps each pair of bytes together
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      stage <= RST_BYTE;
    else if (wr_hi)
      stage <= bus.wdata;
    else if (rd_cnt_lo)
      stage <= count_value[15:8];
    else if (rd_cap_lo)
      stage <= capture_value[15:8];
  end

  // control, mask and power bytes: plain storage
  // writes to an unmapped address change nothing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a    <= RST_BYTE;
      ctrl_b    <= RST_BYTE;
      ctrl_c    <= RST_BYTE;
      mask_reg  <= RST_BYTE;
      power_reg <= RST_POWER;
    end else begin
      if (wr_ctrl_a)
        ctrl_a <= bus.wdata;
      if (wr_ctrl_b)
        ctrl_b <= bus.wdata;
      if (wr_ctrl_c)
        ctrl_c <= bus.wdata;
      // unused mask and power bits read back as zero
      if (wr_mask)
        mask_reg <= bus.wdata & FLAG_USED;
      if (wr_power)
        power_reg <= bus.wdata & 8'h01;
    end
  end

  // flags: write one clears, a new event in the same cycle wins
  // event vector in flag bit order; spare bits never set
  wire [7:0] evt;
  assign evt[FB_OVF]  = count_up;
  assign evt[FB_CMPA] = compare_match[0];
  assign evt[FB_CMPB] = compare_match[1];
  assign evt[FB_CMPC] = compare_match[2];
  assign evt[4]       = 1'b0;
  assign evt[FB_CAP]  = cap_ld;
  assign evt[7:6]     = 2'b00;
  // a flag stays set until software writes a one to it; the hardware
  // event wins when both land on one edge, so no event is ever lost
  wire [7:0] clr = wr_flag ? bus.wdata : 8'h00;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      flag_reg <= RST_BYTE;
    else
      flag_reg <= ((flag_reg & ~clr) | evt) & FLAG_USED;
  end
  // one request line: any set flag whose mask bit is set
  assign irq = |(flag_reg & mask_reg);

  // read mux; compare high bytes come straight from the register.
  // counter and capture high locations show the stage, which the low
  // read has just filled, so a word read is one consistent snapshot
  always_comb begin
    next_rdata = 8'h00;
    unique case (a)
      ADR_CNT_LO:  next_rdata = count_value[7:0];
      ADR_CNT_HI:  next_rdata = stage;
      ADR_CMPA_LO: next_rdata = cmp_buf[0][7:0];
      ADR_CMPA_HI: next_rdata = cmp_buf[0][15:8];
      ADR_CMPB_LO: next_rdata = cmp_buf[1][7:0];
      ADR_CMPB_HI: next_rdata = cmp_buf[1][15:8];
      ADR_CMPC_LO: next_rdata = cmp_buf[2][7:0];
      ADR_CMPC_HI: next_rdata = cmp_buf[2][15:8];
      ADR_CAP_LO:  next_rdata = capture_value[7:0];
      ADR_CAP_HI:  next_rdata = stage;
      ADR_CTRL_A:  next_rdata = ctrl_a;
      ADR_CTRL_B:  next_rdata = ctrl_b;
      ADR_CTRL_C:  next_rdata = ctrl_c;
      ADR_FLAG:    next_rdata = flag_reg;
      ADR_MASK:    next_rdata = mask_reg;
      ADR_POWER:   next_rdata = power_reg;
      default:     next_rdata = 8'h00;
    endcase
  end

  // read data only in the cycle after the strobe; idle cycles return
  // zero so a stale byte can never be mistaken for an answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rdata <= 8'h00;
    else
      rdata <= rd ? next_rdata : 8'h00;
  end
endmodule : stc_timer

// ### sim/stc_cpu.sv
// stc_cpu: byte-wide cpu master for the timer register port
// assumes: read data stand one cycle after the read strobe
`timescale 1ns/100ps
module stc_cpu (
  // clock
  input  wire logic         sys_clk,
  // register port
  output stc_pkg::stc_bus_t bus,
  input  wire logic [7:0]   rdata
);
  import stc_pkg::*;
  initial bus = '0;
  // one strobe cycle, released at the edge that takes it
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd
  // word access; one master only, so the stage is never shared
  task automatic wr16(input logic [4:0] a, input logic [15:0] v);
    wr(a + 5'h01, v[15:8]);
    wr(a, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [4:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 5'h01, v[15:8]);
  endtask : rd16
endmodule : stc_cpu

// ### sim/stc_timer_monitor.sv
// stc_timer_monitor: port-level checks on the 16-bit timer core
// assumes: bound onto stc_timer, one clock domain
`timescale 1ns/100ps
module stc_timer_monitor (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst_b,
  // register port
  input wire stc_pkg::stc_bus_t  bus,
  input wire logic [7:0]         rdata,
  // pins
  input wire logic               presc_tick,
  input wire logic               ext_count_pin,
  input wire logic               capture_input_pin,
  input wire logic               comparator_out,
  // events and status
  input wire logic [2:0]         compare_match,
  input wire logic               pwm_a_allowed,
  input wire stc_pkg::stc_stat_t stat,
  input wire logic               irq
);
  import stc_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // register port answers
  a_rdata_idle: assert property (
    !$past(bus.rd) |-> rdata == 8'h00) else $error("rdata not idle");
  a_unmapped_zero: assert property (
    bus.rd && bus.addr > ADR_POWER |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_power_bits: assert property (
    bus.rd && bus.addr == ADR_POWER |=> rdata[7:1] == 7'h00)
    else $error("power register spare bits set");
  a_flag_bits: assert property (
    bus.rd && (bus.addr == ADR_FLAG || bus.addr == ADR_MASK)
    |=> (rdata & ~FLAG_USED) == 8'h00) else $error("unused flag bit");
  a_mask_off: assert property (
    bus.wr && bus.addr == ADR_MASK && bus.wdata == 8'h00 |=> !irq)
    else $error("irq with all requests masked");
  // word loads through the stage win over counting
  a_load_zero: assert property (
    bus.wr && bus.addr == ADR_CNT_LO && bus.wdata == 8'h00
    && !$past(bus.rd) && $past(bus.wr && bus.addr == ADR_CNT_HI
    && bus.wdata == 8'h00, 2) |=> stat.bottom)
    else $error("zero load not at bottom");
  a_load_max: assert property (
    bus.wr && bus.addr == ADR_CNT_LO && bus.wdata == 8'hff
    && !$past(bus.rd) && $past(bus.wr && bus.addr == ADR_CNT_HI
    && bus.wdata == 8'hff, 2) |=> stat.at_max && !stat.bottom)
    else $error("full load not at max");
  // timer is gated after reset, so the counter sits at zero
  a_reset_idle: assert property (
    $rose(rst_b) |-> stat.bottom [*3]) else $error("counter moved at reset");
endmodule : stc_timer_monitor
bind stc_timer stc_timer_monitor mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
  .presc_tick(presc_tick), .ext_count_pin(ext_count_pin),
  .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
  .compare_match(compare_match), .pwm_a_allowed(pwm_a_allowed),
  .stat(stat), .irq(irq));

// ### sim/test_stc_timer.sv
// test_stc_timer: directed scenarios for the 16-bit timer core
// assumes: stc_cpu drives the register port, pins are driven here
`timescale 1ns/100ps
module test_stc_timer;
  import stc_pkg::*;
  logic        sys_clk, rst_b, presc_tick, ext_count_pin;
  logic        capture_input_pin, comparator_out, pwm_a_allowed, irq;
  logic [7:0]  rdata;
  logic [2:0]  compare_match;
  stc_bus_t    bus;
  stc_stat_t   stat;
  int          err_count, compares;
  stc_timer uut (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .presc_tick(presc_tick), .ext_count_pin(ext_count_pin),
    .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
    .compare_match(compare_match), .pwm_a_allowed(pwm_a_allowed),
    .stat(stat), .irq(irq));
  stc_cpu cpu (.sys_clk(sys_clk), .bus(bus), .rdata(rdata));
  // 125 MHz system clock
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;
  task automatic final_report;
    if (err_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // step past an edge so its updates have landed
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic rb(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
  endtask : rb
  task automatic r16(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    cpu.rd16(a, d);
    chk($sformatf("word %h", a), e, d);
  endtask : r16
  task automatic s_reset;
    for (int a = 0; a < 17; a++) begin
      rb(5'(a), (5'(a) == ADR_POWER) ? RST_POWER : RST_BYTE);
    end
    chk("bottom", 1'b1, stat.bottom);
    cpu.wr(ADR_POWER, 8'hff);
    rb(ADR_POWER, 8'h01);
    cpu.wr(ADR_POWER, 8'h00);
    cpu.wr(ADR_MASK, 8'hff);
    rb(ADR_MASK, FLAG_USED);
    cpu.wr(ADR_MASK, 8'h00);
    cpu.wr(ADR_CTRL_C, 8'ha5);
    rb(ADR_CTRL_C, 8'ha5);
  endtask : s_reset
  // shared stage: reuse, bypass on compare reads
  task automatic s_access;
    cpu.wr16(ADR_CNT_LO, 16'h01ff);
    r16(ADR_CNT_LO, 16'h01ff);
    cpu.wr16(ADR_CMPA_LO, 16'h1234);
    cpu.wr(ADR_CNT_HI, 8'h9a);
    cpu.wr(ADR_CMPB_LO, 8'h56);
    cpu.wr(ADR_CMPC_LO, 8'h78);
    r16(ADR_CMPB_LO, 16'h9a56);
    r16(ADR_CMPC_LO, 16'h9a78);
    cpu.wr(ADR_CNT_HI, 8'h3c);
    r16(ADR_CMPA_LO, 16'h1234);
    rb(ADR_CNT_HI, 8'h3c);
    r16(ADR_CNT_LO, 16'h01ff);
    cpu.wr16(ADR_CNT_LO, 16'hffff);
    #1 chk("max", 1'b1, stat.at_max);
    r16(ADR_CNT_LO, 16'hffff);
  endtask : s_access
  task automatic s_tops;
    logic [2:0]  m [6] = '{TOP_MAX, TOP_8, TOP_9, TOP_10, TOP_CMPA, TOP_CAP};
    logic [15:0] t [6] = '{VAL_MAX, VAL_T8, VAL_T9, VAL_T10,
                           16'h0080, 16'h0100};
    cpu.wr16(ADR_CMPA_LO, 16'h0080);
    for (int k = 0; k < 6; k++) begin
      cpu.wr(ADR_CTRL_B, {2'b00, m[k], CS_STOP});
      cpu.wr16(ADR_CAP_LO, 16'h0100);
      cpu.wr16(ADR_CNT_LO, t[k] - 16'h0004);
      cpu.wr(ADR_CTRL_B, {2'b00, m[k], CS_SYS});
      for (int i = 0; i < 12 && stat.at_top !== 1'b1; i++) tick;
      chk("top", 1'b1, stat.at_top);
      tick;
      chk("wrap", 1'b1, stat.bottom);
    end
  endtask : s_tops
  // a start above the top still runs to the absolute maximum
  task automatic s_count;
    cpu.wr(ADR_FLAG, 8'hff);
    cpu.wr(ADR_MASK, 8'h01);
    cpu.wr(ADR_CTRL_B, {2'b00, TOP_8, CS_SYS});
    cpu.wr16(ADR_CNT_LO, 16'h0000);
    #1 chk("bottom", 1'b1, stat.bottom);
    cpu.wr16(ADR_CNT_LO, 16'hfff0);
    for (int i = 0; i < 40 && stat.at_max !== 1'b1; i++) tick;
    chk("max", 1'b1, stat.at_max);
    tick;
    chk("bottom", 1'b1, stat.bottom);
    for (int i = 0; i < 300 && compare_match[0] !== 1'b1; i++) tick;
    chk("match a", 1'b1, compare_match[0]);
    for (int i = 0; i < 300 && stat.bottom !== 1'b1; i++) tick;
    chk("bottom", 1'b1, stat.bottom);
    chk("irq", 1'b1, irq);
    cpu.wr(ADR_CTRL_B, 8'h00);
    rb(ADR_FLAG, 8'h03);
    cpu.wr(ADR_FLAG, 8'h03);
    #1 chk("irq", 1'b0, irq);
    cpu.wr16(ADR_CNT_LO, 16'h0123);
    repeat (20) tick;
    r16(ADR_CNT_LO, 16'h0123);
    cpu.wr(ADR_FLAG, 8'hff);
    cpu.wr16(ADR_CNT_LO, 16'h9a50);
    cpu.wr(ADR_CTRL_B, {2'b00, TOP_MAX, CS_SYS});
    for (int i = 0; i < 60 && compare_match[2] !== 1'b1; i++) tick;
    chk("match c", 1'b1, compare_match[2]);
    cpu.wr(ADR_CTRL_B, 8'h00);
    rb(ADR_FLAG, 8'h0c);
  endtask : s_count
  task automatic s_capture;
    cpu.wr(ADR_FLAG, 8'hff);
    cpu.wr(ADR_MASK, 8'h20);
    cpu.wr(ADR_CTRL_B, 8'h40);
    cpu.wr16(ADR_CNT_LO, 16'h1234);
    capture_input_pin <= 1'b1;
    for (int i = 0; i < 20 && irq !== 1'b1; i++) tick;
    r16(ADR_CAP_LO, 16'h1234);
    rb(ADR_FLAG, 8'h20);
    cpu.wr(ADR_FLAG, 8'hff);
    cpu.wr(ADR_CTRL_A, 8'h03);
    cpu.wr16(ADR_CNT_LO, 16'h4321);
    comparator_out <= 1'b1;
    for (int i = 0; i < 20 && irq !== 1'b1; i++) tick;
    r16(ADR_CAP_LO, 16'h4321);
    cpu.wr(ADR_CTRL_A, 8'h04);
    cpu.wr(ADR_CTRL_B, {2'b00, TOP_CMPA, CS_STOP});
    #1 chk("pwm a", 1'b0, pwm_a_allowed);
    cpu.wr(ADR_CTRL_B, {2'b00, TOP_CAP, CS_STOP});
    #1 chk("pwm a", 1'b1, pwm_a_allowed);
    cpu.wr(ADR_CTRL_A, 8'h00);
  endtask : s_capture
  // three pulses per source: pin rise, pin fall, prescaler
  task automatic s_clocks;
    logic [2:0] s [3] = '{CS_RISE, CS_FALL, CS_PRE};
    cpu.wr16(ADR_CNT_LO, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      cpu.wr(ADR_CTRL_B, {5'h00, s[k]});
      repeat (3) begin
        presc_tick <= (k == 2);
        ext_count_pin <= (k != 2);
        @(posedge sys_clk);
        presc_tick <= 1'b0;
        repeat (3) @(posedge sys_clk);
        ext_count_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      cpu.wr(ADR_CTRL_B, 8'h00);
      r16(ADR_CNT_LO, 16'(3 * k + 3));
    end
  endtask : s_clocks
  initial begin
    rst_b = 1'b0;
    presc_tick = 1'b0;
    ext_count_pin = 1'b0;
    capture_input_pin = 1'b0;
    comparator_out = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    s_reset;
    s_access;
    s_tops;
    s_count;
    s_capture;
    s_clocks;
    final_report;
  end
  // watchdog: the whole run needs far fewer cycles than this
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    final_report;
  end
endmodule : test_stc_timer
